// ---- pkg/dps_pkg.sv ----
// Behaviour
// - Simple profile maps each function to one control-word bit.
// - Simple profile runs at once when the run bit is set.
// - Simple profile lets control-word bits 1 to 15 be assigned to functions.
// - Standardized profile starts the motor only after the ordered command sequence.
// - Standardized profile assigns only bits 11 to 15 to user functions.
// - Only velocity mode is implemented for reference handling.
// - Separate or combined command and reference sources are selectable.
// - State follows control words and fault events; status word shows it.
// - Initialization state is transient and never shown in the status word.
// - State 2 keeps power stage not ready, motor off, parameters writable.
// - State 3 waits for mains; separate stage needs supply to reach state 4.
// - State 4 has power stage on, no output voltage, motor locked.
// - Configuration write in state 4 drops back to state 2; in the simple profile the state stays at 4.
// - Mains contactor open in states 2 and 3, closed in 4 and 5.
// - State 5 powers motor, but no torque at zero reference or halt.
// - State 5 rejects configuration writes, accepts adjustment writes.
// - Auto-tuning is allowed only in state 5.
// - Enable operation needs a valid channel and, if combined, one reference.
// - Disable operation with stop select 0 freewheels to state 4.
// - Disable operation with stop select 1 ramps down, then enters state 4.
// - Quick stop ramps fast, then state 2 or waits for disable voltage.
// - After fault reaction the fault state disables power, motor locked.
package dps_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_ADJ = 8'h08;
  localparam logic [7:0] ADDR_REF = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TUNE = 8'h14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  localparam logic [31:0] CFG_WMASK = 32'hFFFE_003F;
  localparam logic [31:0] ADJ_RESET = 32'h0000_0000;
  localparam logic [31:0] REF_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Control word fields
  // ****************************************
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT = 8;
  localparam int IO_RUN_BIT = 0;
  localparam logic [15:0] USER_BITS_STD = 16'hF800;
  localparam logic [3:0] CMD_SHUTDOWN_M = 4'h7;
  localparam logic [3:0] CMD_SHUTDOWN_V = 4'h6;
  localparam logic [3:0] CMD_SWITCH_ON_M = 4'hF;
  localparam logic [3:0] CMD_SWITCH_ON_V = 4'h7;
  localparam logic [3:0] CMD_DIS_VOLT_M = 4'h2;
  localparam logic [3:0] CMD_DIS_VOLT_V = 4'h0;
  localparam logic [3:0] CMD_QSTOP_M = 4'h6;
  localparam logic [3:0] CMD_QSTOP_V = 4'h2;
  localparam logic [3:0] CMD_EN_OP_M = 4'hF;
  localparam logic [3:0] CMD_EN_OP_V = 4'hF;
  // ****************************************
  // Status word state codes
  // ****************************************
  localparam logic [15:0] SW_SOD = 16'h0002;
  localparam logic [15:0] SW_RTSO = 16'h0003;
  localparam logic [15:0] SW_SWON = 16'h0004;
  localparam logic [15:0] SW_OPEN = 16'h0005;
  localparam logic [15:0] SW_QSTOP = 16'h0006;
  localparam logic [15:0] SW_FREACT = 16'h0007;
  localparam logic [15:0] SW_FAULT = 16'h0008;
  localparam logic [1:0] RAMP_FREE = 2'h0;
  localparam logic [1:0] RAMP_NORMAL = 2'h1;
  localparam logic [1:0] RAMP_FAST = 2'h2;

  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_SOD = 8'h02,
    ST_RTSO = 8'h04,
    ST_SWON = 8'h08,
    ST_OPEN = 8'h10,
    ST_QSTOP = 8'h20,
    ST_FREACT = 8'h40,
    ST_FAULT = 8'h80
  } dps_state_t;

  typedef struct packed {
    logic [14:0] func_map;
    logic [10:0] rsvd;
    logic contactor;
    logic sep_stage;
    logic qs_mode;
    logic stop_sel;
    logic separate;
    logic profile;
  } dps_cfg_t;

  typedef struct packed {
    logic contactor_close;
    logic power_stage_on;
    logic motor_powered;
    logic [1:0] ramp_sel;
  } dps_power_t;
endpackage

// ---- verilog/dps_drive_profile.sv ----
`timescale 1ns/1ps
module dps_drive_profile
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic mains_ok, // Power stage supply present
  input wire logic channel_valid, // Command channel valid
  input wire logic [15:0] ext_ref, // Reference from separate source
  input wire logic fault_detect, // Detected error
  input wire logic motor_stopped, // Motor at standstill
  input wire logic autotune_done, // Auto-tuning finished
  output dps_pkg::dps_power_t pwr_o, // Power stage control
  output logic [15:0] speed_ref_o, // Velocity reference
  output logic [15:0] func_o, // Assigned function bits
  output logic [15:0] adjust_o, // Adjustment parameter
  output logic tune_busy_o, // Auto-tuning running
  output logic [15:0] profile_state_word // Reported state
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic cw_match(input logic [15:0] cw, input logic [3:0] m,
                                    input logic [3:0] v);
    cw_match = (cw[3:0] & m) == v;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] ctrl_r;
  dps_pkg::dps_cfg_t cfg_r;
  logic [31:0] adj_r;
  logic [31:0] ref_r;
  dps_pkg::dps_state_t state_r;
  dps_pkg::dps_state_t state_nxt;
  logic stopping_r;
  logic stopping_nxt;
  logic ref_seen_r;
  logic tune_busy_r;
  logic fr_prev_r;
  logic do_wr;
  logic wr_err;
  logic cfg_wr;
  logic ref_wr;
  logic tune_wr;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic rd_err;

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;

  always_comb
  begin
    wr_err = 1'b0;
    case (awaddr_r)
      dps_pkg::ADDR_CTRL, dps_pkg::ADDR_ADJ, dps_pkg::ADDR_REF: wr_err = 1'b0;
      dps_pkg::ADDR_CFG: wr_err = (state_r == dps_pkg::ST_OPEN) ||
                                  (state_r == dps_pkg::ST_QSTOP) ||
                                  (state_r == dps_pkg::ST_FREACT);
      dps_pkg::ADDR_TUNE: wr_err = (state_r != dps_pkg::ST_OPEN) || !wdata_r[0];
      default: wr_err = 1'b1;
    endcase
  end

  assign cfg_wr = do_wr && !wr_err && (awaddr_r == dps_pkg::ADDR_CFG);
  assign ref_wr = do_wr && !wr_err && (awaddr_r == dps_pkg::ADDR_REF);
  assign tune_wr = do_wr && !wr_err && (awaddr_r == dps_pkg::ADDR_TUNE);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_hold_r)
    begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (do_wr)
    begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && !w_hold_r)
    begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (do_wr)
    begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= dps_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_err ? dps_pkg::RESP_SLVERR : dps_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // Rejected writes leave every register untouched
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= dps_pkg::CTRL_RESET;
      cfg_r <= dps_pkg::CFG_RESET;
      adj_r <= dps_pkg::ADJ_RESET;
      ref_r <= dps_pkg::REF_RESET;
    end
    else if (do_wr && !wr_err)
    begin
      case (awaddr_r)
        dps_pkg::ADDR_CTRL: ctrl_r <= apply_strb(ctrl_r, wdata_r, wstrb_r) & 32'h0000_FFFF;
        dps_pkg::ADDR_CFG: cfg_r <= apply_strb(cfg_r, wdata_r, wstrb_r) & dps_pkg::CFG_WMASK;
        dps_pkg::ADDR_ADJ: adj_r <= apply_strb(adj_r, wdata_r, wstrb_r) & 32'h0000_FFFF;
        dps_pkg::ADDR_REF: ref_r <= apply_strb(ref_r, wdata_r, wstrb_r) & 32'h0000_FFFF;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  always_comb
  begin
    rd_err = 1'b0;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      dps_pkg::ADDR_CTRL: rd_mux = ctrl_r;
      dps_pkg::ADDR_CFG: rd_mux = cfg_r;
      dps_pkg::ADDR_ADJ: rd_mux = adj_r;
      dps_pkg::ADDR_REF: rd_mux = ref_r;
      dps_pkg::ADDR_STATUS: rd_mux = status_word;
      dps_pkg::ADDR_TUNE: rd_mux = {31'h0000_0000, tune_busy_r};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= dps_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_err ? dps_pkg::RESP_SLVERR : dps_pkg::RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Operating state machine
  // ****************************************
  logic [15:0] cw;
  logic io_mode;
  logic supply_ok;
  logic c_sd;
  logic c_son;
  logic c_dv;
  logic c_qs;
  logic c_eop;
  logic run_io;
  logic halt;
  logic chan_ok;
  logic fr_rise;
  logic [15:0] ref_src;

  assign cw = ctrl_r[15:0];
  assign io_mode = !cfg_r.profile;
  assign supply_ok = !cfg_r.sep_stage || mains_ok;
  assign c_sd = cw_match(cw, dps_pkg::CMD_SHUTDOWN_M, dps_pkg::CMD_SHUTDOWN_V);
  assign c_son = cw_match(cw, dps_pkg::CMD_SWITCH_ON_M, dps_pkg::CMD_SWITCH_ON_V);
  assign c_dv = cw_match(cw, dps_pkg::CMD_DIS_VOLT_M, dps_pkg::CMD_DIS_VOLT_V);
  assign c_qs = cw_match(cw, dps_pkg::CMD_QSTOP_M, dps_pkg::CMD_QSTOP_V);
  assign c_eop = cw_match(cw, dps_pkg::CMD_EN_OP_M, dps_pkg::CMD_EN_OP_V);
  assign run_io = cw[dps_pkg::IO_RUN_BIT];
  assign halt = !io_mode && cw[dps_pkg::CW_HALT];
  assign fr_rise = cw[dps_pkg::CW_FAULT_RST] && !fr_prev_r;
  assign chan_ok = channel_valid && (cfg_r.separate || ref_seen_r);
  assign ref_src = cfg_r.separate ? ext_ref : ref_r[15:0];

  always_comb
  begin
    state_nxt = state_r;
    stopping_nxt = stopping_r;
    if (fault_detect && (state_r != dps_pkg::ST_INIT) &&
        (state_r != dps_pkg::ST_FREACT) && (state_r != dps_pkg::ST_FAULT))
    begin
      state_nxt = dps_pkg::ST_FREACT;
      stopping_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        dps_pkg::ST_INIT: state_nxt = dps_pkg::ST_SOD;
        dps_pkg::ST_SOD, dps_pkg::ST_RTSO, dps_pkg::ST_SWON:
        begin
          if (io_mode)
          begin
            if (run_io && supply_ok && channel_valid)
            begin
              state_nxt = dps_pkg::ST_OPEN;
            end
          end
          else if (state_r == dps_pkg::ST_SOD)
          begin
            if (c_sd)
            begin
              state_nxt = dps_pkg::ST_RTSO;
            end
          end
          else if (c_dv || c_qs)
          begin
            state_nxt = dps_pkg::ST_SOD;
          end
          else if (state_r == dps_pkg::ST_RTSO)
          begin
            if (c_son && supply_ok)
            begin
              state_nxt = dps_pkg::ST_SWON;
            end
          end
          else if (cfg_wr)
          begin
            state_nxt = dps_pkg::ST_SOD;
          end
          else if (c_sd)
          begin
            state_nxt = dps_pkg::ST_RTSO;
          end
          else if (c_eop && chan_ok)
          begin
            state_nxt = dps_pkg::ST_OPEN;
          end
        end
        dps_pkg::ST_OPEN:
        begin
          if (!io_mode && c_dv)
          begin
            state_nxt = dps_pkg::ST_SOD;
            stopping_nxt = 1'b0;
          end
          else if (!io_mode && c_qs)
          begin
            state_nxt = dps_pkg::ST_QSTOP;
            stopping_nxt = 1'b0;
          end
          else if (!io_mode && c_sd)
          begin
            state_nxt = dps_pkg::ST_RTSO;
            stopping_nxt = 1'b0;
          end
          else if (stopping_r)
          begin
            if (motor_stopped)
            begin
              state_nxt = dps_pkg::ST_SWON;
              stopping_nxt = 1'b0;
            end
          end
          else if (io_mode ? !run_io : c_son)
          begin
            if (cfg_r.stop_sel)
            begin
              stopping_nxt = 1'b1;
            end
            else
            begin
              state_nxt = dps_pkg::ST_SWON;
            end
          end
        end
        dps_pkg::ST_QSTOP:
        begin
          if (c_dv || io_mode || (!cfg_r.qs_mode && motor_stopped))
          begin
            state_nxt = dps_pkg::ST_SOD;
          end
        end
        dps_pkg::ST_FREACT:
        begin
          if (motor_stopped)
          begin
            state_nxt = dps_pkg::ST_FAULT;
          end
        end
        dps_pkg::ST_FAULT:
        begin
          if (fr_rise && !fault_detect)
          begin
            state_nxt = dps_pkg::ST_SOD;
          end
        end
        default: state_nxt = dps_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= dps_pkg::ST_INIT;
      stopping_r <= 1'b0;
      fr_prev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      stopping_r <= stopping_nxt;
      fr_prev_r <= cw[dps_pkg::CW_FAULT_RST];
    end
  end

  // Set wins over the loss of a valid channel
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ref_seen_r <= 1'b0;
    end
    else if (ref_wr)
    begin
      ref_seen_r <= 1'b1;
    end
    else if (!channel_valid)
    begin
      ref_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tune_busy_r <= 1'b0;
    end
    else if (tune_wr)
    begin
      tune_busy_r <= 1'b1;
    end
    else if (autotune_done || (state_r != dps_pkg::ST_OPEN))
    begin
      tune_busy_r <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [15:0] sw_code;

  always_comb
  begin
    case (state_r)
      dps_pkg::ST_RTSO: sw_code = dps_pkg::SW_RTSO;
      dps_pkg::ST_SWON: sw_code = dps_pkg::SW_SWON;
      dps_pkg::ST_OPEN: sw_code = dps_pkg::SW_OPEN;
      dps_pkg::ST_QSTOP: sw_code = dps_pkg::SW_QSTOP;
      dps_pkg::ST_FREACT: sw_code = dps_pkg::SW_FREACT;
      dps_pkg::ST_FAULT: sw_code = dps_pkg::SW_FAULT;
      default: sw_code = dps_pkg::SW_SOD;
    endcase
  end

  assign status_word = {11'h000, channel_valid, mains_ok, tune_busy_r, ref_seen_r,
                        stopping_r, sw_code};
  assign tune_busy_o = tune_busy_r;

  // Outputs lag the state by one edge; power logic sees a clean register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pwr_o <= '0;
      speed_ref_o <= 16'h0000;
      func_o <= 16'h0000;
      adjust_o <= 16'h0000;
      profile_state_word <= dps_pkg::SW_SOD;
    end
    else
    begin
      profile_state_word <= sw_code;
      adjust_o <= adj_r[15:0];
      pwr_o.contactor_close <= cfg_r.contactor &&
                               ((state_r == dps_pkg::ST_SWON) || (state_r == dps_pkg::ST_OPEN) ||
                                (state_r == dps_pkg::ST_QSTOP));
      pwr_o.power_stage_on <= (state_r == dps_pkg::ST_SWON) || (state_r == dps_pkg::ST_OPEN) ||
                              (state_r == dps_pkg::ST_QSTOP);
      // no torque at zero or halt
      pwr_o.motor_powered <= (state_r == dps_pkg::ST_QSTOP) ||
                             ((state_r == dps_pkg::ST_OPEN) &&
                              (stopping_r || ((ref_src != 16'h0000) && !halt)));
      case (state_r)
        dps_pkg::ST_OPEN: pwr_o.ramp_sel <= dps_pkg::RAMP_NORMAL;
        dps_pkg::ST_QSTOP: pwr_o.ramp_sel <= dps_pkg::RAMP_FAST;
        default: pwr_o.ramp_sel <= dps_pkg::RAMP_FREE;
      endcase
      speed_ref_o <= ((state_r == dps_pkg::ST_OPEN) && !stopping_r && !halt) ?
                     ref_src : 16'h0000;
      func_o <= io_mode ? (cw & {cfg_r.func_map, 1'b0}) :
                (cw & {cfg_r.func_map, 1'b0} & dps_pkg::USER_BITS_STD);
    end
  end

endmodule

// ---- test/dps_drive_profile_sva.sv ----
`timescale 1ns/1ps
// ****************
// Profile checker
// ****************
module dps_drive_profile_sva
(
  input wire logic ref_clk, // Clock
  input wire logic reset, // Reset
  input wire logic s_axi_awvalid, // Aw valid
  input wire logic s_axi_awready, // Aw ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire dps_pkg::dps_power_t pwr_o, // Power
  input wire logic [15:0] speed_ref_o, // Speed
  input wire logic tune_busy_o, // Tuning
  input wire logic [15:0] profile_state_word // State
);
  logic [15:0] sw;
  logic lock;
  assign sw = profile_state_word;
  assign lock = sw == dps_pkg::SW_SOD || sw == dps_pkg::SW_RTSO || sw == dps_pkg::SW_SWON;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_state_code_range: assert property (sw >= 16'h0002 && sw <= 16'h0008)
    else $error("state code out of range");
  a_open_contactor: assert property (sw <= dps_pkg::SW_RTSO |-> !pwr_o.contactor_close)
    else $error("contactor closed in state 2 or 3");
  a_locked_motor: assert property (lock |-> !pwr_o.motor_powered)
    else $error("motor powered while locked");
  a_stage_not_ready: assert property (sw == dps_pkg::SW_SOD |-> !pwr_o.power_stage_on)
    else $error("power stage on in state 2");
  a_fault_dead: assert property (sw == dps_pkg::SW_FAULT |-> pwr_o == 5'h00)
    else $error("power active in fault state");
  a_ref_zero: assert property (sw != dps_pkg::SW_OPEN |-> speed_ref_o == 16'h0000)
    else $error("speed reference outside state 5");
  a_tune_only_open: assert property (tune_busy_o |->
    sw == dps_pkg::SW_OPEN || $past(sw) == dps_pkg::SW_OPEN)
    else $error("tuning outside state 5");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  c_open: cover property (sw == dps_pkg::SW_OPEN);
  c_fault: cover property (sw == dps_pkg::SW_FAULT);
  c_tune: cover property (tune_busy_o);
endmodule

bind dps_drive_profile dps_drive_profile_sva dps_drive_profile_sva_i (.ref_clk, .reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pwr_o, .speed_ref_o, .tune_busy_o,
  .profile_state_word);

// ---- test/dps_plant_model.sv ----
`timescale 1ns/1ps
// ****************
// Power stage and motor
// ****************
module dps_plant_model
(
  input wire logic ref_clk, // Clock
  input wire logic reset, // Reset
  input wire dps_pkg::dps_power_t pwr, // Power control
  input wire logic tune_busy, // Tuning running
  output logic mains_ok, // Supply present
  output logic motor_stopped, // Standstill
  output logic autotune_done // Tuning over
);
  logic [3:0] spin_r;
  logic [1:0] tune_r;
  // Motor coasts a few cycles after power goes
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      spin_r <= 4'h0;
    else if (pwr.motor_powered)
      spin_r <= 4'h3;
    else if (spin_r != 4'h0)
      spin_r <= spin_r - 4'h1;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      tune_r <= 2'h0;
    else if (!tune_busy)
      tune_r <= 2'h0;
    else if (tune_r != 2'h3)
      tune_r <= tune_r + 2'h1;
  end
  assign mains_ok = !reset;
  assign motor_stopped = spin_r == 4'h0 && !pwr.motor_powered;
  assign autotune_done = tune_r == 2'h3;
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic channel_valid = 1'h0;
  logic fault_detect = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, mains_ok, stopped, tdone, tbusy;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [15:0] spd, func, adj, psw;
  dps_pkg::dps_power_t pwr;
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  dps_drive_profile dps_drive_profile_i (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mains_ok(mains_ok), .channel_valid(channel_valid), .ext_ref(16'h0200),
    .fault_detect(fault_detect), .motor_stopped(stopped), .autotune_done(tdone),
    .pwr_o(pwr), .speed_ref_o(spd), .func_o(func), .adjust_o(adj), .tune_busy_o(tbusy),
    .profile_state_word(psw));
  dps_plant_model dps_plant_model_i (.ref_clk(ref_clk), .reset(reset), .pwr(pwr),
    .tune_busy(tbusy), .mains_ok(mains_ok), .motor_stopped(stopped), .autotune_done(tdone));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  // Ready and answers are taken at the rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, pb;
    int n;
    pb = 1'h1;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40 && pb; n++)
    begin
      @(posedge ref_clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      resp = bresp;
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
      if (tb)
      begin
        bready <= 1'h0;
        pb = 1'h0;
      end
    end
    if (pb)
    begin
      chk("bvalid", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  task rdr(input logic [7:0] a);
    logic ta, tb, pb;
    int n;
    pb = 1'h1;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40 && pb; n++)
    begin
      @(posedge ref_clk);
      ta = arready;
      tb = rvalid;
      rd = rdata;
      resp = rresp;
      if (ta)
        arvalid <= 1'h0;
      if (tb)
      begin
        rready <= 1'h0;
        pb = 1'h0;
      end
    end
    if (pb)
    begin
      chk("rvalid", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  task wst(input logic [15:0] s);
    int n;
    for (n = 0; n < 30 && psw !== s; n++)
      @(negedge ref_clk);
    chk("state", {16'h0000, s}, {16'h0000, psw});
    if (psw !== s)
      tally_and_finish();
  endtask
  task t_reset;
    @(negedge ref_clk);
    chk("state", {16'h0000, dps_pkg::SW_SOD}, {16'h0000, psw});
    chk("power", 32'h0, {27'h0, pwr});
  endtask
  task t_std;
    @(posedge ref_clk);
    channel_valid <= 1'h1;
    wr(dps_pkg::ADDR_CFG, 32'hFFFE_0031);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_000F);
    repeat (4) @(negedge ref_clk);
    chk("state", {16'h0000, dps_pkg::SW_SOD}, {16'h0000, psw});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0006);
    wst(dps_pkg::SW_RTSO);
    chk("contactor", 32'h0, {31'h0, pwr.contactor_close});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0007);
    wst(dps_pkg::SW_SWON);
    chk("contactor", 32'h1, {31'h0, pwr.contactor_close});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_000F);
    repeat (4) @(negedge ref_clk);
    chk("state", {16'h0000, dps_pkg::SW_SWON}, {16'h0000, psw});
    wr(dps_pkg::ADDR_REF, 32'h0000_0100);
    wst(dps_pkg::SW_OPEN);
    chk("speed", 32'h0100, {16'h0000, spd});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_110F);
    repeat (3) @(negedge ref_clk);
    chk("speed", 32'h0, {16'h0000, spd});
    chk("func", 32'h1000, {16'h0000, func});
    wr(dps_pkg::ADDR_CFG, 32'h0000_0031);
    chk("cfg resp", {30'h0, dps_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(dps_pkg::ADDR_ADJ, 32'h0000_1234);
    @(negedge ref_clk);
    chk("adjust", 32'h1234, {16'h0000, adj});
    wr(dps_pkg::ADDR_TUNE, 32'h0000_0001);
    chk("tune resp", {30'h0, dps_pkg::RESP_OKAY}, {30'h0, resp});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0007);
    wst(dps_pkg::SW_SWON);
    wr(dps_pkg::ADDR_TUNE, 32'h0000_0001);
    chk("tune resp", {30'h0, dps_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(dps_pkg::ADDR_CFG, 32'hFFFE_0031);
    wst(dps_pkg::SW_SOD);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0006);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0007);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_000F);
    wst(dps_pkg::SW_OPEN);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_000B);
    wst(dps_pkg::SW_QSTOP);
    chk("ramp", {30'h0, dps_pkg::RAMP_FAST}, {30'h0, pwr.ramp_sel});
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0000);
    wst(dps_pkg::SW_SOD);
  endtask
  task t_fault;
    @(posedge ref_clk);
    fault_detect <= 1'h1;
    wst(dps_pkg::SW_FAULT);
    chk("power", 32'h0, {27'h0, pwr});
    @(posedge ref_clk);
    fault_detect <= 1'h0;
    wr(dps_pkg::ADDR_CTRL, 32'h0000_0080);
    wst(dps_pkg::SW_SOD);
  endtask
  task t_simple;
    wr(dps_pkg::ADDR_CFG, 32'hFFFE_0002);
    wr(dps_pkg::ADDR_CTRL, 32'h0000_8003);
    wst(dps_pkg::SW_OPEN);
    chk("func", 32'h8002, {16'h0000, func});
    chk("speed", 32'h0200, {16'h0000, spd});
    rdr(dps_pkg::ADDR_STATUS);
    chk("status", 32'h0005, {16'h0000, rd[15:0]});
    rdr(8'h40);
    chk("read resp", {30'h0, dps_pkg::RESP_SLVERR}, {30'h0, resp});
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    t_reset();
    t_std();
    t_fault();
    t_simple();
    tally_and_finish();
  end
endmodule
